// ===== inc/charger_settings_pkg.sv
// Package of constants for the charger function settings register bank.
// Assumes an internal register port from the serial control interface decoder.
package charger_settings_pkg;

	// ---------------------------------------------------------------
	// Register addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_SETTINGS_ONE = 8'h07;
	localparam logic [7:0] ADDR_SETTINGS_TWO = 8'h08;

	// ---------------------------------------------------------------
	// Field positions, settings one
	// ---------------------------------------------------------------
	localparam int BIT_CHIP_DISABLE       = 6;
	localparam int BIT_MONITOR_FORCE_ON   = 5;
	localparam int BIT_THERMISTOR_FORCE   = 4;
	localparam int BIT_REGULATOR_OFF      = 3;
	localparam int BIT_END_OF_CHARGE_OK   = 2;
	localparam int BIT_CHARGE_ENABLE      = 0;
	localparam logic [7:0] MASK_SETTINGS_ONE = 8'h7D;

	// ---------------------------------------------------------------
	// Field positions, settings two
	// ---------------------------------------------------------------
	localparam int BIT_TEMP_PROFILE_ENABLE = 7;
	localparam int BIT_TEMP_PROFILE_SELECT = 6;
	localparam int BIT_VOLTAGE_LIMIT       = 5;
	localparam int DIODE_MSB               = 4;
	localparam int DIODE_LSB               = 3;
	localparam int SYSV_MSB                = 2;
	localparam int SYSV_LSB                = 0;

	// ---------------------------------------------------------------
	// Encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] DIODE_ALWAYS    = 2'h0;
	localparam logic [1:0] DIODE_WEAK_GATE = 2'h1;
	localparam logic [7:0] RESET_SETTINGS_ONE = 8'h04;
	localparam logic [7:0] RESET_SETTINGS_TWO = 8'h07;

endpackage

// ===== rtl/settings_reg8.sv
// One 8-bit settings register with a per-bit writable mask.
// Assumes a one-cycle write strobe synchronous to the system clock.
`timescale 1ns/10ps
`default_nettype none
module settings_reg8 #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	// Write port
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	// Stored value
	output logic      [7:0] o_value
);
	logic [7:0] next_value;

	always_comb begin
		next_value = o_value;
		if (i_wr) begin
			next_value = i_wdata & WRITE_MASK;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_value <= RESET_VALUE;
		end else begin
			o_value <= next_value;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/charger_function_settings.sv
// Charger function settings: two host registers and the controls they drive.
// Assumes the serial interface gives an address, a write strobe and data.
//
// Overview of operation
// - Settings one bit 6 disables chip
// - Bit 5 forces battery monitor on
// - Bit 4 forces thermistor source on
// - Bit 3 turns regulator off, default on
// - Regulator off: isolation switch opens when charge enable is set, closes when clear
// - Bit 2 allows end of charge, default 1
// - Bit 0 enables charging, default 0
// - Settings two bit 7 enables temperature profile
// - Bit 6 selects second temperature profile
// - Bit 5 withholds charge above voltage limit
// - Diode field: always, weak gated, disabled
// - System voltage code, 4.3 to 5.0 V
// - Registers decode at 0x07 and 0x08
`timescale 1ns/10ps
`default_nettype none
module charger_function_settings (
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	// Register port
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	// Analog conditions
	input  wire logic       i_input_valid,
	input  wire logic       i_system_below_battery,
	input  wire logic       i_battery_above_weak,
	input  wire logic       i_battery_below_limit,
	// Controls
	output logic            o_chip_disable,
	output logic            o_battery_monitor_on,
	output logic            o_thermistor_source_on,
	output logic            o_regulator_on,
	output logic            o_isolation_switch_closed,
	output logic            o_end_of_charge_allowed,
	output logic            o_charge_enable,
	output logic            o_charge_permit,
	output logic            o_temp_profile_enable,
	output logic            o_temp_profile_select,
	output logic            o_ideal_diode_on,
	output logic      [2:0] o_system_voltage_code
);
	logic [7:0] settings_one;
	logic [7:0] settings_two;
	logic       wr_one;
	logic       wr_two;
	logic [7:0] next_rdata;
	logic       regulator_off;
	logic [1:0] diode_mode;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	always_comb begin
		wr_one = 1'b0;
		wr_two = 1'b0;
		if (i_reg_addr == charger_settings_pkg::ADDR_SETTINGS_ONE) begin
			wr_one = i_reg_wr;
		end else if (i_reg_addr == charger_settings_pkg::ADDR_SETTINGS_TWO) begin
			wr_two = i_reg_wr;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	settings_reg8 #(
		.RESET_VALUE (charger_settings_pkg::RESET_SETTINGS_ONE),
		.WRITE_MASK  (charger_settings_pkg::MASK_SETTINGS_ONE)
	) u_one (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_one),
		.i_wdata   (i_reg_wdata),
		.o_value   (settings_one)
	);

	settings_reg8 #(
		.RESET_VALUE (charger_settings_pkg::RESET_SETTINGS_TWO),
		.WRITE_MASK  (8'hFF)
	) u_two (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_wr      (wr_two),
		.i_wdata   (i_reg_wdata),
		.o_value   (settings_two)
	);

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (i_reg_addr == charger_settings_pkg::ADDR_SETTINGS_ONE) begin
			next_rdata = settings_one & charger_settings_pkg::MASK_SETTINGS_ONE;
		end else if (i_reg_addr == charger_settings_pkg::ADDR_SETTINGS_TWO) begin
			next_rdata = settings_two;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else begin
			o_reg_rdata <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Controls
	// ---------------------------------------------------------------
	assign regulator_off = settings_one[charger_settings_pkg::BIT_REGULATOR_OFF];
	assign diode_mode    = settings_two[charger_settings_pkg::DIODE_MSB:charger_settings_pkg::DIODE_LSB];

	always_comb begin
		o_chip_disable          = settings_one[charger_settings_pkg::BIT_CHIP_DISABLE];
		o_battery_monitor_on    = i_input_valid
			| settings_one[charger_settings_pkg::BIT_MONITOR_FORCE_ON];
		o_thermistor_source_on  = i_input_valid
			| settings_one[charger_settings_pkg::BIT_THERMISTOR_FORCE];
		o_regulator_on          = ~regulator_off;
		o_end_of_charge_allowed = settings_one[charger_settings_pkg::BIT_END_OF_CHARGE_OK];
		o_charge_enable         = settings_one[charger_settings_pkg::BIT_CHARGE_ENABLE];
		o_temp_profile_enable   = settings_two[charger_settings_pkg::BIT_TEMP_PROFILE_ENABLE];
		o_temp_profile_select   = settings_two[charger_settings_pkg::BIT_TEMP_PROFILE_SELECT];
		o_system_voltage_code   = settings_two[charger_settings_pkg::SYSV_MSB:charger_settings_pkg::SYSV_LSB];
		// Isolation switch closed by default; regulator off hands it to charge enable
		o_isolation_switch_closed = 1'b1;
		if (regulator_off) begin
			o_isolation_switch_closed = ~settings_one[charger_settings_pkg::BIT_CHARGE_ENABLE];
		end
		o_charge_permit = settings_one[charger_settings_pkg::BIT_CHARGE_ENABLE];
		if (settings_two[charger_settings_pkg::BIT_VOLTAGE_LIMIT]) begin
			o_charge_permit = o_charge_permit & i_battery_below_limit;
		end
		if (diode_mode == charger_settings_pkg::DIODE_ALWAYS) begin
			o_ideal_diode_on = i_system_below_battery;
		end else if (diode_mode == charger_settings_pkg::DIODE_WEAK_GATE) begin
			o_ideal_diode_on = i_system_below_battery & i_battery_above_weak;
		end else begin
			o_ideal_diode_on = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== test/charger_settings_assertions.sv
// Checker bound to the charger settings bank.
// Assumes one clock with asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module charger_settings_assertions (
	input wire logic       i_clk_sys, i_rst, i_reg_wr, i_input_valid, i_system_below_battery,
	input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
	input wire logic       o_chip_disable, o_battery_monitor_on, o_regulator_on, o_isolation_switch_closed,
	input wire logic       o_charge_enable, o_charge_permit, o_ideal_diode_on,
	input wire logic [2:0] o_system_voltage_code
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	wire logic w1 = i_reg_wr && i_reg_addr == 8'h07;
	wire logic w2 = i_reg_wr && i_reg_addr == 8'h08;
	chk_chip_off: assert property (w1 |=> o_chip_disable == $past(i_reg_wdata[6])) else $error("chip off");
	chk_monitor_on: assert property (i_input_valid |-> o_battery_monitor_on) else $error("monitor");
	chk_iso_switch: assert property (!o_regulator_on |-> o_isolation_switch_closed != o_charge_enable)
		else $error("isolation");
	chk_charge_load: assert property (w1 |=> o_charge_enable == $past(i_reg_wdata[0])) else $error("charge");
	chk_permit_gate: assert property (!o_charge_enable |-> !o_charge_permit) else $error("permit");
	chk_diode_off: assert property (!i_system_below_battery |-> !o_ideal_diode_on) else $error("diode");
	chk_volt_load: assert property (w2 |=> o_system_voltage_code == $past(i_reg_wdata[2:0])) else $error("volt");
	chk_unmapped_read: assert property (!($past(i_reg_addr) inside {8'h07, 8'h08}) |-> o_reg_rdata == 8'h00)
		else $error("unmapped");
	cover property (w1 && i_reg_wdata[3] && i_reg_wdata[0]);
	cover property (o_ideal_diode_on);
	cover property (w2);
endmodule
bind charger_function_settings charger_settings_assertions u_chk (.*);
`default_nettype wire

// ===== test/host_model.sv
// Host model driving the settings register port.
// Assumes put is called just after a falling edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic       i_clk_sys,
	output var  logic [7:0] o_addr = 8'h00,
	output var  logic       o_wr = 1'b0,
	output var  logic [7:0] o_wdata = 8'h00
);
	task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
		o_addr = a;
		o_wr = w;
		o_wdata = w ? d : ~o_wdata;
		@(posedge i_clk_sys);
		@(negedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

// ===== test/tb_charger_function_settings.sv
// Self-checking bench for the charger settings bank.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(e, g) check(e, g)
module tb_charger_function_settings;
	logic clk = 0, rst = 1, iv = 0, sb = 0, aw = 0, bl = 0, pend = 0;
	logic [7:0] s1 = 8'h04, s2 = 8'h07, a;
	logic [31:0] seed = 32'h2051_d50e;
	logic [21:0] q[$];
	wire logic [7:0] addr, wdata, rdata;
	wire logic wr;
	wire logic [13:0] obs;
	int n_fail = 0, total_checks = 0;
	always #20 clk = ~clk;
	host_model u_host (.i_clk_sys(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
	charger_function_settings u_dut (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_input_valid(iv), .i_system_below_battery(sb),
		.i_battery_above_weak(aw), .i_battery_below_limit(bl), .o_chip_disable(obs[13]),
		.o_battery_monitor_on(obs[12]), .o_thermistor_source_on(obs[11]), .o_regulator_on(obs[10]),
		.o_isolation_switch_closed(obs[9]), .o_end_of_charge_allowed(obs[8]), .o_charge_enable(obs[7]),
		.o_charge_permit(obs[6]), .o_temp_profile_enable(obs[5]), .o_temp_profile_select(obs[4]),
		.o_ideal_diode_on(obs[3]), .o_system_voltage_code(obs[2:0]));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [13:0] expo();
		return {s1[6], iv | s1[5], iv | s1[4], ~s1[3], ~s1[3] | ~s1[0], s1[2], s1[0], s1[0] & (~s2[5] | bl),
			s2[7:6], s2[4] ? 1'b0 : sb & (~s2[3] | aw), s2[2:0]};
	endfunction
	task automatic check(input logic [21:0] e, input logic [21:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic rd(input logic [7:0] x);
		q.push_back({x == 8'h07 ? s1 : x == 8'h08 ? s2 : 8'h00, expo()});
		pend = 1;
		u_host.put(x, 8'h00, 1'b0);
	endtask
	always @(posedge clk) begin
		#1;
		if (pend) `CHK(q.pop_front(), {rdata, obs});
	end
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 0;
		rd(8'h07);
		rd(8'h08);
		$display("test reset_defaults done");
		repeat (80) begin
			seed = xs(seed);
			{iv, sb, aw, bl} = seed[3:0];
			a = seed[5] ? seed[15:8] : {4'h0, seed[4] ? 4'h7 : 4'h8};
			pend = 0;
			u_host.put(a, seed[31:24], 1'b1);
			if (a == 8'h07) s1 = seed[31:24] & 8'h7D;
			if (a == 8'h08) s2 = seed[31:24];
			rd(a);
		end
		$display("test random_access done");
		pend = 0;
		rst = 1;
		@(negedge clk);
		rst = 0;
		s1 = 8'h04;
		s2 = 8'h07;
		rd(8'h07);
		rd(8'h08);
		$display("test second_reset done");
		print_verdict();
	end
	initial begin
		#40000;
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
